// ===== hw/wscr_bank.sv
/*
 * Wake source configuration register bank with per-input wake filters.
 * Assumes the device's SPI decoder presents one decoded register access per
 * cycle on access_strobe, and that mode control signals restart and
 * fail-safe entry as one-cycle pulses.
 */
`timescale 1ns/1ps

module wscr_bank (
	// Clock and reset.
	input  wire logic                        ref_clk,
	input  wire logic                        rst,
	// Register access from the SPI decoder.
	input  wire logic                        access_strobe,
	input  wire wscr_pkg::wscr_access_type   access,
	output logic      [7:0]                  read_data,
	output logic                             addr_hit,
	// Mode events from the device state machine.
	input  wire logic                        restart_pulse,
	input  wire logic                        failsafe_entry,
	input  wire logic                        watchdog_stop_disable_set,
	input  wire logic                        normal_mode,
	// Wake inputs and cyclic timer windows.
	input  wire logic [2:0]                  wake_input_level,
	input  wire logic                        timer_a_on_end,
	input  wire logic                        timer_b_on_end,
	input  wire logic                        timer_a_wake_event,
	input  wire logic                        timer_b_wake_event,
	input  wire logic                        other_status_event,
	// Configuration and result outputs.
	output logic                             cyclic_timer_a_wake_enable,
	output logic                             cyclic_timer_b_wake_enable,
	output logic                             watchdog_stop_disable,
	output logic                             sense_measure_select,
	output logic                             measure_active,
	output logic      [5:0]                  wake_input_bias,
	output logic      [2:0]                  wake_input_enable_eff,
	output logic      [2:0]                  wake_input_filtered,
	output logic                             wake_event,
	output logic                             interrupt_request,
	output wscr_pkg::wscr_override_type      bus_one_override,
	output wscr_pkg::wscr_override_type      bus_two_override
);

	logic [7:0] internal_wake_control;
	logic [7:0] external_wake_control;
	logic [7:0] wake_input_bias_control;
	logic [7:0] wake_input_filter_control;
	logic [7:0] next_internal;
	logic [7:0] next_external;
	logic [7:0] next_bias;
	logic [7:0] next_filter;
	logic [2:0] stable_level;
	logic [2:0] last_level;
	logic [2:0] input_edge;
	logic       timer_wake;

	wire wr_int = access_strobe && access.write && access.addr == wscr_pkg::ADDR_INTERNAL_WAKE_CONTROL;
	wire wr_ext = access_strobe && access.write && access.addr == wscr_pkg::ADDR_EXTERNAL_WAKE_CONTROL;
	wire wr_bias = access_strobe && access.write && access.addr == wscr_pkg::ADDR_WAKE_INPUT_BIAS_CONTROL;
	wire wr_flt = access_strobe && access.write && access.addr == wscr_pkg::ADDR_WAKE_INPUT_FILTER_CONTROL;

	// Restart keeps only retained bits; software write follows; fail-safe forces last.
	wire [7:0] int_base = restart_pulse ?
		(internal_wake_control & wscr_pkg::RESTART_KEEP_INTERNAL) : internal_wake_control;
	wire [7:0] int_wr = wr_int ? (access.wdata & wscr_pkg::MASK_INTERNAL) : int_base;
	// The device may set the watchdog disable bit itself; set wins over a write.
	assign next_internal = int_wr | ((watchdog_stop_disable_set ? 8'h04 : 8'h00)
		& wscr_pkg::MASK_INTERNAL);

	wire [7:0] ext_base = restart_pulse ?
		(external_wake_control & wscr_pkg::RESTART_KEEP_EXTERNAL) : external_wake_control;
	wire [7:0] ext_wr = wr_ext ? (access.wdata & wscr_pkg::MASK_EXTERNAL) : ext_base;
	assign next_external = failsafe_entry ?
		((ext_wr & ~wscr_pkg::FAILSAFE_EXTERNAL_FORCE) |
		(wscr_pkg::FAILSAFE_EXTERNAL_VALUE & wscr_pkg::FAILSAFE_EXTERNAL_FORCE)) : ext_wr;

	wire [7:0] bias_base = restart_pulse ?
		(wake_input_bias_control & wscr_pkg::RESTART_KEEP_BIAS) : wake_input_bias_control;
	assign next_bias = wr_bias ? (access.wdata & wscr_pkg::MASK_BIAS) : bias_base;
	wire [7:0] flt_base = restart_pulse ?
		(wake_input_filter_control & wscr_pkg::RESTART_KEEP_FILTER) : wake_input_filter_control;
	assign next_filter = wr_flt ? (access.wdata & wscr_pkg::MASK_FILTER) : flt_base;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			internal_wake_control     <= wscr_pkg::RESET_INTERNAL;
			external_wake_control     <= wscr_pkg::RESET_EXTERNAL;
			wake_input_bias_control   <= wscr_pkg::RESET_BIAS;
			wake_input_filter_control <= wscr_pkg::RESET_FILTER;
		end else begin
			internal_wake_control     <= next_internal;
			external_wake_control     <= next_external;
			wake_input_bias_control   <= next_bias;
			wake_input_filter_control <= next_filter;
		end
	end

	// Read mux; reserved bits are already stored as zero.
	assign addr_hit = access.addr inside {wscr_pkg::ADDR_INTERNAL_WAKE_CONTROL,
		wscr_pkg::ADDR_EXTERNAL_WAKE_CONTROL, wscr_pkg::ADDR_WAKE_INPUT_BIAS_CONTROL,
		wscr_pkg::ADDR_WAKE_INPUT_FILTER_CONTROL};
	wire [7:0] read_sel =
		(access.addr == wscr_pkg::ADDR_INTERNAL_WAKE_CONTROL) ? internal_wake_control :
		(access.addr == wscr_pkg::ADDR_EXTERNAL_WAKE_CONTROL) ? external_wake_control :
		(access.addr == wscr_pkg::ADDR_WAKE_INPUT_BIAS_CONTROL) ? wake_input_bias_control :
		(access.addr == wscr_pkg::ADDR_WAKE_INPUT_FILTER_CONTROL) ? wake_input_filter_control :
		8'h00;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			read_data <= 8'h00;
		end else if (access_strobe && !access.write) begin
			read_data <= read_sel;
		end
	end

	assign cyclic_timer_b_wake_enable = internal_wake_control[wscr_pkg::BIT_TIMER_B_WAKE];
	assign cyclic_timer_a_wake_enable = internal_wake_control[wscr_pkg::BIT_TIMER_A_WAKE];
	assign watchdog_stop_disable = internal_wake_control[wscr_pkg::BIT_WD_STOP_DIS];
	assign sense_measure_select = external_wake_control[wscr_pkg::BIT_MEASURE_SELECT];
	assign measure_active = sense_measure_select && normal_mode;
	assign wake_input_bias = wake_input_bias_control[5:0];

	// Enables of inputs A and B are ignored while sense_measure_select is set, whether or not normal_mode is high.
	assign wake_input_enable_eff[2] = external_wake_control[wscr_pkg::BIT_INPUT_C_EN];
	assign wake_input_enable_eff[1] = external_wake_control[wscr_pkg::BIT_INPUT_B_EN]
		&& !sense_measure_select;
	assign wake_input_enable_eff[0] = external_wake_control[wscr_pkg::BIT_INPUT_A_EN]
		&& !sense_measure_select;

	genvar gi;
	generate
		for (gi = 0; gi < wscr_pkg::NUM_INPUTS; gi++) begin : g_filter
			wscr_wake_filter u_filter (
				.ref_clk     (ref_clk),
				.rst         (rst),
				.filter_code (wake_input_filter_control[gi*2 +: 2]),
				.level       (wake_input_level[gi]),
				.timer_a_end (timer_a_on_end),
				.timer_b_end (timer_b_on_end),
				.stable      (stable_level[gi])
			);
		end
	endgenerate
	assign wake_input_filtered = stable_level;

	assign input_edge = (stable_level ^ last_level) & wake_input_enable_eff;
	assign timer_wake = (timer_a_wake_event && cyclic_timer_a_wake_enable) ||
		(timer_b_wake_event && cyclic_timer_b_wake_enable);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			last_level        <= 3'h0;
			wake_event        <= 1'b0;
			interrupt_request <= 1'b0;
		end else begin
			last_level        <= stable_level;
			wake_event        <= |input_edge || timer_wake;
			interrupt_request <= |input_edge || timer_wake ||
				(external_wake_control[wscr_pkg::BIT_INT_GLOBAL] && other_status_event);
		end
	end

	// Fail-safe override patterns for the two bus control registers.
	assign bus_one_override.force_mask = failsafe_entry ? wscr_pkg::FAILSAFE_BUS_ONE_FORCE : 8'h00;
	assign bus_one_override.value = wscr_pkg::FAILSAFE_BUS_ONE_VALUE;
	assign bus_two_override.force_mask = failsafe_entry ? wscr_pkg::FAILSAFE_BUS_TWO_FORCE : 8'h00;
	assign bus_two_override.value = wscr_pkg::FAILSAFE_BUS_TWO_VALUE;

endmodule // wscr_bank

module wscr_wake_filter (
	// Clock and reset.
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// Configuration and sensing.
	input  wire logic [1:0] filter_code,
	input  wire logic       level,
	input  wire logic       timer_a_end,
	input  wire logic       timer_b_end,
	output logic            stable
);

	logic [12:0] count;
	logic [1:0]  active_code;
	logic        busy;
	wire  [12:0] short_len = 13'(wscr_pkg::FILTER_SHORT_CYCLES);
	wire  [12:0] long_len = 13'(wscr_pkg::FILTER_LONG_CYCLES);
	wire  [12:0] limit = (active_code == wscr_pkg::FILTER_STATIC_LONG) ? long_len : short_len;
	wire         cyc = filter_code[1];
	// Cyclic codes start a window only at the end of the selected timer on-time.
	wire         cyc_start = (filter_code == wscr_pkg::FILTER_CYCLIC_A && timer_a_end) ||
		(filter_code == wscr_pkg::FILTER_CYCLIC_B && timer_b_end);
	wire         start = !busy && (cyc ? cyc_start : level != stable);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			count       <= 13'h0;
			active_code <= 2'h0;
			busy        <= 1'b0;
			stable      <= 1'b0;
		end else if (start) begin
			active_code <= filter_code;
			count       <= 13'h1;
			busy        <= 1'b1;
		end else if (busy) begin
			if (!active_code[1] && level == stable) begin
				busy <= 1'b0;
			end else if (count >= limit) begin
				busy <= 1'b0;
				if (active_code[1]) begin
					stable <= level;
				end else begin
					stable <= level;
				end
			end else begin
				count <= count + 13'h1;
			end
		end
	end

endmodule // wscr_wake_filter

// ===== hw/wscr_pkg.sv
/*
 * Package for the wake source configuration register bank: register
 * addresses, field positions, reset and override patterns, filter timing.
 * Assumes a 100 MHz reference clock.
 */
package wscr_pkg;

	localparam logic [6:0] ADDR_INTERNAL_WAKE_CONTROL     = 7'h06;
	localparam logic [6:0] ADDR_EXTERNAL_WAKE_CONTROL     = 7'h07;
	localparam logic [6:0] ADDR_WAKE_INPUT_BIAS_CONTROL   = 7'h08;
	localparam logic [6:0] ADDR_WAKE_INPUT_FILTER_CONTROL = 7'h09;

	// Writable bits of each register; all other positions read zero.
	localparam logic [7:0] MASK_INTERNAL = 8'hC4;
	localparam logic [7:0] MASK_EXTERNAL = 8'hA7;
	localparam logic [7:0] MASK_BIAS     = 8'h3F;
	localparam logic [7:0] MASK_FILTER   = 8'h3F;

	localparam logic [7:0] RESET_INTERNAL = 8'h00;
	localparam logic [7:0] RESET_EXTERNAL = 8'h07;
	localparam logic [7:0] RESET_BIAS     = 8'h00;
	localparam logic [7:0] RESET_FILTER   = 8'h00;

	// Restart keeps the bits set in these masks and clears the rest.
	localparam logic [7:0] RESTART_KEEP_INTERNAL = 8'h00;
	localparam logic [7:0] RESTART_KEEP_EXTERNAL = 8'hA7;
	localparam logic [7:0] RESTART_KEEP_BIAS     = 8'h3F;
	localparam logic [7:0] RESTART_KEEP_FILTER   = 8'h3F;

	// Fail-safe overrides: value bits and which bits are forced.
	localparam logic [7:0] FAILSAFE_EXTERNAL_VALUE = 8'h07;
	localparam logic [7:0] FAILSAFE_EXTERNAL_FORCE = 8'h5F;
	localparam logic [7:0] FAILSAFE_BUS_ONE_VALUE  = 8'h09;
	localparam logic [7:0] FAILSAFE_BUS_ONE_FORCE  = 8'h1F;
	localparam logic [7:0] FAILSAFE_BUS_TWO_VALUE  = 8'h01;
	localparam logic [7:0] FAILSAFE_BUS_TWO_FORCE  = 8'hFF;

	localparam int BIT_TIMER_B_WAKE   = 7;
	localparam int BIT_TIMER_A_WAKE   = 6;
	localparam int BIT_WD_STOP_DIS    = 2;
	localparam int BIT_INT_GLOBAL     = 7;
	localparam int BIT_MEASURE_SELECT = 5;
	localparam int BIT_INPUT_C_EN     = 2;
	localparam int BIT_INPUT_B_EN     = 1;
	localparam int BIT_INPUT_A_EN     = 0;
	localparam int NUM_INPUTS         = 3;
	localparam int FIELD_WIDTH        = 2;

	localparam logic [1:0] FILTER_STATIC_SHORT = 2'h0;
	localparam logic [1:0] FILTER_STATIC_LONG  = 2'h1;
	localparam logic [1:0] FILTER_CYCLIC_A     = 2'h2;
	localparam logic [1:0] FILTER_CYCLIC_B     = 2'h3;

	localparam int CLOCK_MHZ          = 100;
	localparam int FILTER_SHORT_US    = 16;
	localparam int FILTER_LONG_US     = 64;
	localparam int FILTER_SHORT_CYCLES = FILTER_SHORT_US * CLOCK_MHZ;
	localparam int FILTER_LONG_CYCLES  = FILTER_LONG_US * CLOCK_MHZ;
	localparam int COUNT_WIDTH         = 13;

	typedef struct packed {
		logic       write;
		logic [6:0] addr;
		logic [7:0] wdata;
	} wscr_access_type;

	typedef struct packed {
		logic [7:0] force_mask;
		logic [7:0] value;
	} wscr_override_type;

endpackage

// ===== test/testbench.sv
/*
 * Self-checking bench for wscr_bank: readback, restart, fail-safe, wake filters.
 * Assumes a 100 MHz ref_clk and the host model for register access.
 */
`timescale 1ns/1ps

module testbench;
	logic                      ref_clk, rst, restart_pulse, failsafe_entry, normal_mode;
	logic                      watchdog_stop_disable_set, timer_a_on_end, timer_b_on_end;
	logic                      timer_a_wake_event, timer_b_wake_event, other_status_event;
	logic                      access_strobe, wake_event, interrupt_request, rd_pend, lv;
	logic [2:0]                wake_input_level, wake_input_filtered;
	logic [7:0]                read_data, wake_seen, irq_seen, w0, d;
	wscr_pkg::wscr_access_type access;
	logic [7:0]                exp_q [$];
	logic [7:0]                rst_val [5] = '{8'h00, 8'h07, 8'h00, 8'h00, 8'h00};
	logic [7:0]                mask [5] = '{8'hC4, 8'hA7, 8'h3F, 8'h3F, 8'h00};
	int                        seed = 72971, bad_count = 0, n_tests = 0, cyc = 0, i, k;
	wire  [7:0]                filt_c = {7'h00, wake_input_filtered[2]};
	wscr_host wscr_host_i (.ref_clk, .access_strobe, .access);
	wscr_bank wscr_bank_i (.ref_clk, .rst, .access_strobe, .access, .read_data, .addr_hit(),
		.restart_pulse, .failsafe_entry, .watchdog_stop_disable_set, .normal_mode,
		.wake_input_level, .timer_a_on_end, .timer_b_on_end, .timer_a_wake_event,
		.timer_b_wake_event, .other_status_event, .cyclic_timer_a_wake_enable(),
		.cyclic_timer_b_wake_enable(), .watchdog_stop_disable(), .sense_measure_select(),
		.measure_active(), .wake_input_bias(), .wake_input_enable_eff(), .wake_input_filtered,
		.wake_event, .interrupt_request, .bus_one_override(), .bus_two_override());
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		n_tests++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	// A read notes its expected value; it is also driven as harmless write data.
	task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
		if (!w) exp_q.push_back(d);
		wscr_host_i.drive(w, a, d);
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		rd_pend <= access_strobe && !access.write;
		if (rd_pend === 1'b1) chk("read_data", exp_q.pop_front(), read_data);
		if (wake_event === 1'b1) wake_seen <= wake_seen + 8'h01;
		if (interrupt_request === 1'b1) irq_seen <= irq_seen + 8'h01;
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			bad_count++;
			close_out();
		end
	end
	initial begin
		{rst, restart_pulse, failsafe_entry, watchdog_stop_disable_set, normal_mode} = 5'h10;
		{timer_a_on_end, timer_b_on_end, timer_a_wake_event, timer_b_wake_event} = 4'h0;
		{other_status_event, rd_pend, lv, wake_input_level, wake_seen, irq_seen} = '0;
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		for (i = 0; i < 5; i++) acc(1'b0, 7'(6 + i), rst_val[i]);
		for (i = 0; i < 20; i++) begin
			d = (i < 5) ? 8'hFF : 8'($random(seed));
			normal_mode <= 1'($random(seed));
			acc(1'b1, 7'(6 + i % 5), d);
			acc(1'b0, 7'(6 + i % 5), d & mask[i % 5]);
		end
		$display("readback done");
		acc(1'b1, 7'h06, 8'hC4);
		acc(1'b1, 7'h07, 8'hFF);
		acc(1'b1, 7'h08, 8'h2A);
		@(posedge ref_clk) restart_pulse <= 1'b1;
		@(posedge ref_clk) restart_pulse <= 1'b0;
		acc(1'b0, 7'h06, 8'h00);
		acc(1'b0, 7'h07, 8'hA7);
		acc(1'b0, 7'h08, 8'h2A);
		$display("restart done");
		for (i = 0; i < 2; i++) begin
			acc(1'b1, 7'h07, i ? 8'h00 : 8'hA0);
			@(posedge ref_clk) failsafe_entry <= 1'b1;
			@(posedge ref_clk) failsafe_entry <= 1'b0;
			acc(1'b0, 7'h07, i ? 8'h07 : 8'hA7);
		end
		acc(1'b1, 7'h06, 8'hC0);
		@(posedge ref_clk) watchdog_stop_disable_set <= 1'b1;
		@(posedge ref_clk) watchdog_stop_disable_set <= 1'b0;
		acc(1'b0, 7'h06, 8'hC4);
		$display("fail-safe and watchdog done");
		for (i = 0; i < 6; i++) begin
			// Pass 4 clears the interrupt scope bit, so the other status event must stay silent.
			d = (i < 2) ? 8'h40 : (i < 4) ? 8'h80 : (i == 4) ? 8'h07 : 8'h87;
			acc(1'b1, i < 4 ? 7'h06 : 7'h07, d);
			{w0, d} = {wake_seen, irq_seen};
			@(posedge ref_clk)
			{other_status_event, timer_b_wake_event, timer_a_wake_event} <= 3'(i < 4 ? 1 << i % 2 : 4);
			@(posedge ref_clk) {other_status_event, timer_b_wake_event, timer_a_wake_event} <= 3'h0;
			repeat (3) @(posedge ref_clk);
			chk("timer wake", w0 + 8'(i == 0 || i == 3), wake_seen);
			chk("interrupt", d + 8'(i == 0 || i == 3 || i == 5), irq_seen);
		end
		$display("timer wake and interrupt scope done");
		for (k = 0; k < 4; k++) begin
			acc(1'b1, 7'h09, 8'(k << 4));
			acc(1'b1, 7'h08, 8'($random(seed)) & 8'h3F);
			w0 = wake_seen;
			lv = ~lv;
			wake_input_level <= {lv, 2'b00};
			// Timer end pulses stand in for a timer assigned to a high-side switch.
			if (k > 1) begin
				@(posedge ref_clk) {timer_b_on_end, timer_a_on_end} <= 2'(4 - k);
				@(posedge ref_clk) {timer_b_on_end, timer_a_on_end} <= 2'h0;
				repeat (1700) @(posedge ref_clk);
				chk("cyclic idle", {7'h00, ~lv}, filt_c);
				@(posedge ref_clk) {timer_b_on_end, timer_a_on_end} <= 2'(k - 1);
				@(posedge ref_clk) {timer_b_on_end, timer_a_on_end} <= 2'h0;
			end
			repeat ((k == 1 ? 6400 : 1600) - 50) @(posedge ref_clk);
			chk("filter early", {7'h00, ~lv}, filt_c);
			repeat (100) @(posedge ref_clk);
			chk("filter late", {7'h00, lv}, filt_c);
			chk("input wake", w0 + 8'h01, wake_seen);
		end
		$display("filters done");
		// Filtered levels of inputs a and b are not looked at while measuring.
		acc(1'b1, 7'h07, 8'h23);
		w0 = wake_seen;
		normal_mode <= 1'b1;
		wake_input_level <= {lv, 2'b11};
		repeat (1700) @(posedge ref_clk);
		chk("measure wake", w0, wake_seen);
		$display("measurement done");
		close_out();
	end
endmodule // testbench

// ===== test/wscr_asserts.sv
/*
 * Concurrent checks on the ports of wscr_bank, bound to every instance.
 * Assumes the single ref_clk domain with synchronous active-high rst.
 */
`timescale 1ns/1ps

module wscr_asserts (
	// Clock and reset.
	input wire logic                        ref_clk,
	input wire logic                        rst,
	// Bank inputs.
	input wire logic                        access_strobe,
	input wire wscr_pkg::wscr_access_type   access,
	input wire logic                        failsafe_entry,
	input wire logic                        watchdog_stop_disable_set,
	input wire logic                        normal_mode,
	input wire logic                        timer_a_wake_event,
	input wire logic                        timer_b_wake_event,
	// Bank outputs.
	input wire logic                        addr_hit,
	input wire logic                        cyclic_timer_a_wake_enable,
	input wire logic                        cyclic_timer_b_wake_enable,
	input wire logic                        watchdog_stop_disable,
	input wire logic                        sense_measure_select,
	input wire logic                        measure_active,
	input wire logic [2:0]                  wake_input_enable_eff,
	input wire logic                        wake_event,
	input wire logic                        interrupt_request,
	input wire wscr_pkg::wscr_override_type bus_one_override,
	input wire wscr_pkg::wscr_override_type bus_two_override
);
	wire ext_wr    = access_strobe && access.write && access.addr == 7'h07;
	wire meas_bit  = access.wdata[5];
	wire c_en_bit  = access.wdata[2];
	wire timer_hit = timer_a_wake_event && cyclic_timer_a_wake_enable
		|| timer_b_wake_event && cyclic_timer_b_wake_enable;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	hit_decode_a: assert property (addr_hit == (access.addr inside {[7'h06:7'h09]}))
		else $error("address decode wrong");
	meas_gate_a: assert property (sense_measure_select |-> !wake_input_enable_eff[1:0])
		else $error("inputs a or b enabled while measuring");
	meas_mode_a: assert property (measure_active == (sense_measure_select && normal_mode))
		else $error("measure_active wrong");
	wd_set_a: assert property (watchdog_stop_disable_set |=> watchdog_stop_disable)
		else $error("device set of watchdog bit lost");
	fs_force_a: assert property (failsafe_entry |-> {bus_one_override, bus_two_override} == 32'h1F09FF01)
		else $error("fail-safe bus override wrong");
	fs_quiet_a: assert property (!failsafe_entry |-> !bus_one_override.force_mask)
		else $error("bus override forced outside fail-safe entry");
	fs_wake_a: assert property (failsafe_entry |=> wake_input_enable_eff[2])
		else $error("input c not enabled after fail-safe entry");
	timer_wake_a: assert property (timer_hit |=> wake_event && interrupt_request)
		else $error("enabled timer wake not reported");
	wake_irq_a: assert property (wake_event |-> interrupt_request)
		else $error("wake event without interrupt");
	ext_wr_a: assert property (ext_wr && !failsafe_entry |=>
		sense_measure_select == $past(meas_bit) && wake_input_enable_eff[2] == $past(c_en_bit))
		else $error("external control write not applied");
	cover property (timer_hit ##1 wake_event);
	cover property (failsafe_entry);
	cover property (measure_active);
endmodule // wscr_asserts

bind wscr_bank wscr_asserts wscr_asserts_i (.ref_clk, .rst, .access_strobe, .access,
	.failsafe_entry, .watchdog_stop_disable_set, .normal_mode, .timer_a_wake_event,
	.timer_b_wake_event, .addr_hit, .cyclic_timer_a_wake_enable, .cyclic_timer_b_wake_enable,
	.watchdog_stop_disable, .sense_measure_select, .measure_active, .wake_input_enable_eff,
	.wake_event, .interrupt_request, .bus_one_override, .bus_two_override);

// ===== test/wscr_host.sv
/*
 * Host model issuing single register accesses to the wake configuration bank.
 * Assumes an access is taken at the first rising edge with access_strobe high.
 */
`timescale 1ns/1ps

module wscr_host (
	// Clock.
	input  wire logic                 ref_clk,
	// Register access.
	output logic                      access_strobe,
	output wscr_pkg::wscr_access_type access
);
	initial begin
		access_strobe = 1'b0;
		access        = '1;
	end
	// Bus transceiver modes are kept elsewhere, so only the bank is reached here.
	task automatic drive(input logic w, input logic [6:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		access_strobe <= 1'b1;
		access        <= '{write: w, addr: a, wdata: d};
		@(posedge ref_clk);
		access_strobe <= 1'b0;
		access        <= ~access;
	endtask
endmodule // wscr_host
